// [bench/ledr_peer.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Link peer model
// ----------------------------------------------------------------
module ledr_peer (
  input  wire logic                       clock,
  output var  ledr_pkg::ledr_err_type     err,
  output var  ledr_pkg::ledr_credit_type  credit,
  output var  ledr_pkg::ledr_traffic_type traffic
);
  initial
  begin
    err     = '0;
    credit  = '0;
    traffic = '0;
  end

  // A gap follows every error pulse, so each pulse is one error.
  // Index 0 is a bad TLP, 1 a bad DLLP, 2 a list RAM and 3 a packet RAM error.
  task automatic pulse_err(input int idx, input int n);
    repeat (n)
    begin
      @(posedge clock);
      err <= ledr_pkg::ledr_err_type'(4'h8 >> idx);
      @(posedge clock);
      err <= '0;
    end
  endtask : pulse_err

  // Requests arrive back to back while the link state is held.
  task automatic link_req(input logic dn, input int n);
    @(posedge clock);
    traffic.dl_down   <= dn;
    traffic.req_valid <= 1'b1;
    repeat (n) @(posedge clock);
    traffic.req_valid <= 1'b0;
  endtask : link_req

  task automatic stream(input logic [10:0] len, input int n);
    @(posedge clock);
    traffic.payload_valid <= 1'b1;
    traffic.payload_len   <= len;
    repeat (n) @(posedge clock);
    traffic.payload_valid <= 1'b0;
  endtask : stream

  // A credit update goes with every change of the stall pattern.
  task automatic set_stall(input logic [2:0] s);
    @(posedge clock);
    credit <= {s, 1'b1};
    @(posedge clock);
    credit.credit_update <= 1'b0;
  endtask : set_stall
endmodule : ledr_peer
`default_nettype wire

// [bench/link_egress_diag_registers_test.sv]
`timescale 1ns/10ps
`default_nettype none
module link_egress_diag_registers_test;
  localparam int MS = 20;
  localparam logic [11:0] OFFS [6] = '{12'h1E4, 12'h1E8, 12'h1EC, 12'h1F0, 12'h1F8, 12'h100};
  localparam logic [2:0]  STALLS [3] = '{3'h7, 3'h4, 3'h6};
  localparam logic [3:0]  CLASSES [3] = '{4'h0, 4'h2, 4'h1};
  logic                       clock;
  logic                       rstn;
  ledr_pkg::ledr_bus_type     bus;
  logic [31:0]                rdata;
  ledr_pkg::ledr_err_type     err;
  ledr_pkg::ledr_credit_type  credit;
  ledr_pkg::ledr_traffic_type traffic;
  logic                       link_down;
  logic                       ur_report;
  logic                       req_discard;
  logic [7:0]                 ack_latency;
  logic                       irq;
  int                         failures;
  int                         comparisons;
  int                         n_ur;
  int                         n_dis;
  int                         n_ld;
  int                         n;
  int                         t;
  logic [31:0]                d;
  logic [31:0]                v;
  logic [2:0]                 ctl;
  logic [7:0]                 llc;
  logic [7:0]                 prc;

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ledr_regs #(.MS_CYCLES(MS)) u_dut (
    .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .err(err),
    .credit(credit), .traffic(traffic), .link_down(link_down),
    .ur_report(ur_report), .req_discard(req_discard),
    .ack_latency(ack_latency), .irq(irq));

  ledr_peer u_peer (.clock(clock), .err(err), .credit(credit), .traffic(traffic));

  always @(posedge clock)
  begin
    if (ur_report === 1'b1) n_ur++;
    if (req_discard === 1'b1) n_dis++;
    if (link_down === 1'b1) n_ld++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] val);
    @(posedge clock);
    bus <= '{addr: a, wdata: val, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] val);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 val = rdata;
  endtask : rd_reg

  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask : settle

  function automatic logic [31:0] exp_egress(input logic [3:0] cls);
    return {prc, 4'h0, cls, llc, 5'h00, ctl};
  endfunction : exp_egress

  function automatic logic [31:0] in_window(input logic sel, input int ticks);
    int lo;
    lo = sel ? 1024 : 512;
    return {31'h0, ticks >= lo * MS && ticks <= (lo + 256) * MS};
  endfunction : in_window

  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h907AEDD8));
    {failures, comparisons, n_ur, n_dis, n_ld} = '0;
    rstn = 1'b0;
    bus  = '0;
    llc  = 8'h00;
    prc  = 8'h00;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    foreach (OFFS[i])
    begin
      rd_reg(OFFS[i], d);
      chk(d, (i == 4) ? 32'h000000FF : 32'h0, "reset value");
    end
    chk({24'h0, ack_latency}, 32'hFF, "ack out at reset");
    $display("test reset finished");

    v = $urandom;
    wr_reg(12'h1E4, v & 32'hFFFFFFFE);
    ctl = {v[2:1], 1'b0};
    rd_reg(12'h1E4, d);
    chk(d, exp_egress(4'h0), "control bits");
    foreach (STALLS[i])
    begin
      v = {16'($urandom), 16'h00FF};
      v[7:0] = (i == 0) ? 8'h76 : (i == 1) ? 8'hD9 : 8'hFF;
      wr_reg(12'h1F8, v);
      rd_reg(12'h1F8, d);
      chk(d, {24'h0, v[7:0]}, "ack latency");
      chk({24'h0, ack_latency}, {24'h0, v[7:0]}, "ack out");
    end
    $display("test control finished");

    for (int i = 0; i < 4; i++)
    begin
      n = 1 + $urandom % 20;
      u_peer.pulse_err(i, n);
      settle();
      if (i == 2) llc = 8'(n);
      if (i == 3) prc = 8'(n);
      rd_reg(i < 2 ? OFFS[i + 1] : 12'h1E4, d);
      chk(d, i < 2 ? 32'(n) : exp_egress(4'h0), "error count");
    end
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(OFFS[i + 1], 32'hFFFFFFFD);
      rd_reg(OFFS[i + 1], d);
      chk(d, 32'hFD, "count write");
      u_peer.pulse_err(i, 4);
      settle();
      rd_reg(OFFS[i + 1], d);
      chk(d, 32'hFF, "saturation");
    end
    $display("test counters finished");

    wr_reg(12'h1E4, 32'h0);
    u_peer.link_req(1'b1, 3);
    settle();
    chk(32'(n_ur), 32'd3, "ur in mode 0");
    u_peer.link_req(1'b0, 2);
    wr_reg(12'h1E4, 32'h4);
    u_peer.link_req(1'b1, 3);
    settle();
    chk(32'(n_ur), 32'd4, "ur in mode 1");
    chk(32'(n_dis), 32'd2, "discards");
    u_peer.link_req(1'b0, 1);
    $display("test link down finished");

    v = 32'(1 + $urandom % 2047);
    fork
      u_peer.stream(v[10:0], 70);
      begin
        repeat (50) @(posedge clock);
        rd_reg(12'h1F0, d);
        chk(d, v * MS, "payload sum");
      end
    join
    repeat (45) @(posedge clock);
    rd_reg(12'h1F0, d);
    chk(d, 32'h0, "payload restart");
    $display("test payload finished");

    foreach (STALLS[i])
    begin
      wr_reg(12'h1E4, {30'h0, i == 1, 1'b1});
      ctl = {1'b0, i == 1, 1'b1};
      u_peer.set_stall(STALLS[i]);
      for (t = 0; t < 1300 * MS && link_down !== 1'b1; t++)
      begin
        @(posedge clock);
        #1;
      end
      if (t == 1300 * MS)
      begin
        failures++;
        report_and_stop();
      end
      chk(in_window(i == 1, t), 32'h1, "timeout time");
      u_peer.set_stall(3'h0);
      rd_reg(12'h1E4, d);
      chk(d, exp_egress(CLASSES[i]), "timeout class");
    end
    wr_reg(12'h1E4, 32'h0);
    u_peer.set_stall(3'h7);
    repeat (800 * MS) @(posedge clock);
    u_peer.set_stall(3'h0);
    chk(32'(n_ld), 32'd3, "timer off");
    $display("test watchdog finished");

    rd_reg(12'h1F4, d);
    chk(d, 32'hF, "irq status");
    wr_reg(12'h1D4, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr_reg(12'h1FC, 32'hD);
    rd_reg(12'h1F4, d);
    chk(d, 32'h2, "irq partial clear");
    wr_reg(12'h1D4, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr_reg(12'h1D4, 32'h2);
    wr_reg(12'h1FC, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd_reg(12'h1FC, d);
    chk(d, 32'h0, "clear reads zero");
    u_peer.pulse_err(0, 1);
    settle();
    chk({31'h0, irq}, 32'h1, "irq again");
    $display("test interrupt finished");
    report_and_stop();
  end
endmodule : link_egress_diag_registers_test
`default_nettype wire

// [core/ledr_pkg.sv]
// Behaviour
// - While the credit timer enable bit is set, a credit stall that lasts past the timeout brings the downstream link down; clear, the timer is off.
// - The timeout select bit picks a timeout between 512 and 768 ms when 0 and between 1,024 and 1,280 ms when 1.
// - With the link-down handling bit at 0, every request received while the data link is down is answered with an unsupported-request error.
// - With that bit at 1, only the first request received in the link-down state gets an unsupported-request error and later ones are silently dropped.
// - A read-only 8-bit counter in bits 15:8 counts single-bit soft errors of the link-list, de-allocation and scheduler RAMs.
// - On an egress timeout, read-only bits 19:16 record the class: 0h posted, 1h non-posted, 2h completion.
// - A read-only 8-bit counter in bits 31:24 counts single-bit soft errors seen on packet RAM reads.
// - An 8-bit field in bits 7:0 counts received TLPs with a bad LCRC or a sequence mismatch.
// - An 8-bit field in bits 7:0 of its own register counts received DLLPs with a bad LCRC or a sequence mismatch.
// - Both bad packet counters stop at FFh and never wrap to 00h.
// - A 21-bit field in bits 20:0 gives the payload moved over the link in each 1 ms period.
// - The 8-bit ACK latency limit in bits 7:0 resets to FFh and drives the link layer (FFh x1, D9h x2, 76h x4).
package ledr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFF_EGRESS      = 12'h1E4;
  localparam logic [11:0] OFF_BAD_TLP     = 12'h1E8;
  localparam logic [11:0] OFF_BAD_DLLP    = 12'h1EC;
  localparam logic [11:0] OFF_PAYLOAD     = 12'h1F0;
  localparam logic [11:0] OFF_ACK_LAT     = 12'h1F8;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h1F4;
  localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h1FC;
  localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h1D4;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_TMR_EN      = 0;
  localparam int          BIT_TMO_SEL     = 1;
  localparam int          BIT_DLDN_MODE   = 2;
  localparam int          CNT_W           = 8;
  localparam int          PAY_W           = 21;
  localparam int          LEN_W           = 11;
  localparam int          ACK_W           = 16;
  localparam int          IRQ_W           = 4;
  localparam logic [7:0]  CNT_MAX         = 8'hFF;
  localparam logic [15:0] ACK_RESET       = 16'h00FF;
  localparam logic [3:0]  CLS_POSTED      = 4'h0;
  localparam logic [3:0]  CLS_NONPOSTED   = 4'h1;
  localparam logic [3:0]  CLS_COMPLETION  = 4'h2;

  // Interrupt status bit positions.
  localparam int          IRQ_TIMEOUT     = 0;
  localparam int          IRQ_BAD_TLP     = 1;
  localparam int          IRQ_BAD_DLLP    = 2;
  localparam int          IRQ_SOFT_ERR    = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          MS_NS           = 1000000;
  localparam int          MS_CYCLES_DEF   = MS_NS / CLK_PERIOD_NS;
  localparam int          TMO_SHORT_MS    = 512;
  localparam int          TMO_LONG_MS     = 1024;
  // The millisecond tick is free running, so one extra tick keeps the
  // stall at or above the least time and well under the longest.
  localparam logic [10:0] TMO_SHORT_TICKS = 11'(TMO_SHORT_MS + 1);
  localparam logic [10:0] TMO_LONG_TICKS  = 11'(TMO_LONG_MS + 1);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } ledr_bus_type;

  typedef struct packed {
    logic tlp_bad;
    logic dllp_bad;
    logic llist_soft_err;
    logic pram_soft_err;
  } ledr_err_type;

  typedef struct packed {
    logic [2:0] stalled;
    logic       credit_update;
  } ledr_credit_type;

  typedef struct packed {
    logic             dl_down;
    logic             req_valid;
    logic             payload_valid;
    logic [LEN_W-1:0] payload_len;
  } ledr_traffic_type;

endpackage : ledr_pkg

// [core/ledr_regs.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ledr_regs #(
  parameter int MS_CYCLES = ledr_pkg::MS_CYCLES_DEF
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire ledr_pkg::ledr_bus_type    bus,
  output var  logic [31:0]               rdata,
  input  wire ledr_pkg::ledr_err_type    err,
  input  wire ledr_pkg::ledr_credit_type credit,
  input  wire ledr_pkg::ledr_traffic_type traffic,
  output var  logic                      link_down,
  output var  logic                      ur_report,
  output var  logic                      req_discard,
  output var  logic [7:0]                ack_latency,
  output var  logic                      irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                         tmr_en;
  logic                         tmo_sel;
  logic                         dldn_mode;
  logic [ledr_pkg::CNT_W-1:0]   llist_cnt;
  logic [ledr_pkg::CNT_W-1:0]   pram_cnt;
  logic [3:0]                   tmo_class;
  logic [ledr_pkg::CNT_W-1:0]   tlp_cnt;
  logic [ledr_pkg::CNT_W-1:0]   dllp_cnt;
  logic [ledr_pkg::PAY_W-1:0]   payload;
  logic [ledr_pkg::PAY_W-1:0]   pay_acc;
  logic [ledr_pkg::ACK_W-1:0]   ack_reg;
  logic [ledr_pkg::IRQ_W-1:0]   irq_status;
  logic [ledr_pkg::IRQ_W-1:0]   irq_enable;
  logic [31:0]                  ms_cnt;
  logic                         ms_tick;
  logic [10:0]                  wd_cnt;
  logic [10:0]                  wd_limit;
  logic                         wd_expire;
  logic                         ur_sent;
  logic [3:0]                   next_class;
  logic [ledr_pkg::PAY_W:0]     next_acc;
  logic [ledr_pkg::IRQ_W-1:0]   events;

  logic wr_egress;
  logic wr_tlp;
  logic wr_dllp;
  logic wr_pay;
  logic wr_ack;
  logic wr_clr;
  logic wr_ien;

  assign wr_egress = bus.wr && (bus.addr == ledr_pkg::OFF_EGRESS);
  assign wr_tlp    = bus.wr && (bus.addr == ledr_pkg::OFF_BAD_TLP);
  assign wr_dllp   = bus.wr && (bus.addr == ledr_pkg::OFF_BAD_DLLP);
  assign wr_pay    = bus.wr && (bus.addr == ledr_pkg::OFF_PAYLOAD);
  assign wr_ack    = bus.wr && (bus.addr == ledr_pkg::OFF_ACK_LAT);
  assign wr_clr    = bus.wr && (bus.addr == ledr_pkg::OFF_IRQ_CLEAR);
  assign wr_ien    = bus.wr && (bus.addr == ledr_pkg::OFF_IRQ_ENABLE);

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tmr_en    <= 1'b0;
      tmo_sel   <= 1'b0;
      dldn_mode <= 1'b0;
    end
    // only the defined control bits are stored
    else if (wr_egress)
    begin
      tmr_en    <= bus.wdata[ledr_pkg::BIT_TMR_EN];
      tmo_sel   <= bus.wdata[ledr_pkg::BIT_TMO_SEL];
      dldn_mode <= bus.wdata[ledr_pkg::BIT_DLDN_MODE];
    end
  end

  // ----------------------------------------------------------------
  // Millisecond base and credit watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b0;
    end
    else if (ms_cnt == 32'(MS_CYCLES - 1))
    begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b1;
    end
    else
    begin
      ms_cnt  <= ms_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  assign wd_limit  = tmo_sel ? ledr_pkg::TMO_LONG_TICKS : ledr_pkg::TMO_SHORT_TICKS;
  assign wd_expire = tmr_en && (|credit.stalled) && !credit.credit_update
                     && (wd_cnt >= wd_limit);

  always_comb
  begin
    if (credit.stalled[0])
      next_class = ledr_pkg::CLS_POSTED;
    else if (credit.stalled[1])
      next_class = ledr_pkg::CLS_NONPOSTED;
    else
      next_class = ledr_pkg::CLS_COMPLETION;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wd_cnt    <= 11'h0;
      link_down <= 1'b0;
    end
    else if (!tmr_en || credit.credit_update || !(|credit.stalled) || wd_expire)
    begin
      wd_cnt    <= 11'h0;
      link_down <= wd_expire;
    end
    else
    begin
      wd_cnt    <= ms_tick ? wd_cnt + 11'h1 : wd_cnt;
      link_down <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      tmo_class <= ledr_pkg::CLS_POSTED;
    else if (wd_expire)
      tmo_class <= next_class;
  end

  // ----------------------------------------------------------------
  // Requests while the data link is down
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ur_sent     <= 1'b0;
      ur_report   <= 1'b0;
      req_discard <= 1'b0;
    end
    else if (!traffic.dl_down)
    begin
      ur_sent     <= 1'b0;
      ur_report   <= 1'b0;
      req_discard <= 1'b0;
    end
    else
    begin
      ur_report   <= traffic.req_valid && (!dldn_mode || !ur_sent);
      req_discard <= traffic.req_valid && dldn_mode && ur_sent;
      if (traffic.req_valid)
        ur_sent <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  // Software may preset the bad packet counters; a write beats an error
  // arriving in the same cycle.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tlp_cnt  <= 8'h00;
      dllp_cnt <= 8'h00;
    end
    else
    begin
      if (wr_tlp)
        tlp_cnt <= bus.wdata[ledr_pkg::CNT_W-1:0];
      else if (err.tlp_bad && tlp_cnt != ledr_pkg::CNT_MAX)
        tlp_cnt <= tlp_cnt + 8'h01;
      if (wr_dllp)
        dllp_cnt <= bus.wdata[ledr_pkg::CNT_W-1:0];
      else if (err.dllp_bad && dllp_cnt != ledr_pkg::CNT_MAX)
        dllp_cnt <= dllp_cnt + 8'h01;
    end
  end

  // Soft error counters hold at the top so a long burst is not hidden.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      llist_cnt <= 8'h00;
      pram_cnt  <= 8'h00;
    end
    else
    begin
      if (err.llist_soft_err && llist_cnt != ledr_pkg::CNT_MAX)
        llist_cnt <= llist_cnt + 8'h01;
      if (err.pram_soft_err && pram_cnt != ledr_pkg::CNT_MAX)
        pram_cnt <= pram_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Payload per millisecond
  // ----------------------------------------------------------------
  assign next_acc = {1'b0, pay_acc}
                    + (ledr_pkg::PAY_W + 1)'(traffic.payload_valid ? traffic.payload_len : '0);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pay_acc <= '0;
      payload <= '0;
    end
    else if (ms_tick)
    begin
      pay_acc <= '0;
      payload <= next_acc[ledr_pkg::PAY_W] ? '1 : next_acc[ledr_pkg::PAY_W-1:0];
    end
    else
    begin
      pay_acc <= next_acc[ledr_pkg::PAY_W] ? '1 : next_acc[ledr_pkg::PAY_W-1:0];
      if (wr_pay)
        payload <= bus.wdata[ledr_pkg::PAY_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // ACK latency limit
  // ----------------------------------------------------------------
  // limit and test field
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ack_reg <= ledr_pkg::ACK_RESET;
    else if (wr_ack)
      ack_reg <= bus.wdata[ledr_pkg::ACK_W-1:0];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ack_latency <= ledr_pkg::ACK_RESET[7:0];
    else
      ack_latency <= ack_reg[7:0];
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign events[ledr_pkg::IRQ_TIMEOUT]  = wd_expire;
  assign events[ledr_pkg::IRQ_BAD_TLP]  = err.tlp_bad;
  assign events[ledr_pkg::IRQ_BAD_DLLP] = err.dllp_bad;
  assign events[ledr_pkg::IRQ_SOFT_ERR] = err.llist_soft_err | err.pram_soft_err;

  // A clear in the same cycle as a new event keeps the bit set.
  genvar gi;
  generate
    for (gi = 0; gi < ledr_pkg::IRQ_W; gi++)
    begin : g_status
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          irq_status[gi] <= 1'b0;
        else if (events[gi])
          irq_status[gi] <= 1'b1;
        else if (wr_clr && bus.wdata[gi])
          irq_status[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_enable <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_ien)
        irq_enable <= bus.wdata[ledr_pkg::IRQ_W-1:0];
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // reserved bits read zero
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0;
    else if (!bus.rd)
      rdata <= 32'h0;
    else if (bus.addr == ledr_pkg::OFF_EGRESS)
      rdata <= {pram_cnt, 4'h0, tmo_class, llist_cnt, 5'h00, dldn_mode, tmo_sel, tmr_en};
    else if (bus.addr == ledr_pkg::OFF_BAD_TLP)
      rdata <= {24'h0, tlp_cnt};
    else if (bus.addr == ledr_pkg::OFF_BAD_DLLP)
      rdata <= {24'h0, dllp_cnt};
    else if (bus.addr == ledr_pkg::OFF_PAYLOAD)
      rdata <= {11'h0, payload};
    else if (bus.addr == ledr_pkg::OFF_ACK_LAT)
      rdata <= {16'h0, ack_reg};
    else if (bus.addr == ledr_pkg::OFF_IRQ_STATUS)
      rdata <= {28'h0, irq_status};
    else if (bus.addr == ledr_pkg::OFF_IRQ_ENABLE)
      rdata <= {28'h0, irq_enable};
    else
      rdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_timer_off;
    !tmr_en |=> !link_down;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("link taken down with timer off");

  property p_wd_bound;
    wd_cnt <= wd_limit;
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("watchdog ran past its limit");

  property p_ur_all;
    traffic.dl_down && traffic.req_valid && !dldn_mode |=> ur_report && !req_discard;
  endproperty
  a_ur_all: assert property (p_ur_all) else $error("request in link down not reported");

  sequence s_first_req;
    traffic.dl_down && dldn_mode && traffic.req_valid;
  endsequence
  sequence s_later_req;
    traffic.dl_down && dldn_mode && traffic.req_valid && !bus.wr;
  endsequence
  property p_drop_later;
    s_first_req ##1 s_later_req |=> req_discard && !ur_report;
  endproperty
  a_drop_later: assert property (p_drop_later) else $error("later request not dropped");

  property p_llist_inc;
    err.llist_soft_err && llist_cnt != ledr_pkg::CNT_MAX |=> llist_cnt == $past(llist_cnt) + 8'h01;
  endproperty
  a_llist_inc: assert property (p_llist_inc) else $error("link-list count missed");

  property p_class;
    link_down |-> tmo_class <= ledr_pkg::CLS_COMPLETION;
  endproperty
  a_class: assert property (p_class) else $error("bad timeout class code");

  property p_pram_inc;
    err.pram_soft_err && pram_cnt != ledr_pkg::CNT_MAX |=> pram_cnt == $past(pram_cnt) + 8'h01;
  endproperty
  a_pram_inc: assert property (p_pram_inc) else $error("packet RAM count missed");

  property p_tlp_inc;
    err.tlp_bad && !wr_tlp && tlp_cnt != ledr_pkg::CNT_MAX |=> tlp_cnt == $past(tlp_cnt) + 8'h01;
  endproperty
  a_tlp_inc: assert property (p_tlp_inc) else $error("bad_tlp_counter missed");

  property p_dllp_inc;
    err.dllp_bad && !wr_dllp && dllp_cnt != ledr_pkg::CNT_MAX |=> dllp_cnt == $past(dllp_cnt) + 8'h01;
  endproperty
  a_dllp_inc: assert property (p_dllp_inc) else $error("bad_dllp_counter missed");

  property p_saturate;
    tlp_cnt == ledr_pkg::CNT_MAX && !wr_tlp |=> tlp_cnt == ledr_pkg::CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("bad_tlp_counter wrapped");

  property p_interval;
    ms_tick && !next_acc[ledr_pkg::PAY_W] |=> payload == $past(next_acc[ledr_pkg::PAY_W-1:0]) && pay_acc == '0 || traffic.payload_valid;
  endproperty
  a_interval: assert property (p_interval) else $error("interval total not loaded");

  property p_ack_out;
    wr_ack |-> ##2 ack_latency == $past(bus.wdata[7:0], 2);
  endproperty
  a_ack_out: assert property (p_ack_out) else $error("latency limit not applied");

endmodule : ledr_regs
`default_nettype wire
